/* pkg/cpu_bus_map.svh */
// bus cycle constants: status codes, byte-lane codes, sync depth
`ifndef CPU_BUS_MAP_SVH
`define CPU_BUS_MAP_SVH
`define ST_INT_ACK   3'h0
`define ST_IO_READ   3'h1
`define ST_IO_WRITE  3'h2
`define ST_HALT      3'h3
`define ST_CODE_READ 3'h4
`define ST_MEM_READ  3'h5
`define ST_MEM_WRITE 3'h6
`define ST_PASSIVE   3'h7
`define LANE_WORD    2'h0
`define LANE_HIGH    2'h1
`define LANE_LOW     2'h2
`define LANE_NONE    2'h3
`define VECTOR_SHIFT 2
`define SYNC_STAGES  3
`endif

/* pkg/cpu_bus_pkg.sv */
// types for the local bus cycle engine
`default_nettype none
package cpu_bus_pkg;
   typedef enum logic [2:0] {
      cyc_code_read, cyc_mem_read, cyc_io_read, cyc_mem_write,
      cyc_io_write, cyc_int_ack, cyc_halt
   } cycle_kind_t;
   typedef enum {
      idle, state_one, state_two, state_three, wait_state, state_four
   } bus_state_t;
endpackage
`default_nettype wire

/* logic/pin_sync.sv */
// three-stage synchroniser; change accepted when stages two and three agree
`default_nettype none
`include "cpu_bus_map.svh"
module pin_sync #(
   parameter logic init = 1'b0
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic pin,
   output logic      level
);
   logic [`SYNC_STAGES-1:0] sh_q;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sh_q  <= {`SYNC_STAGES{init}};
         level <= init;
      end else begin
         sh_q <= {sh_q[`SYNC_STAGES-2:0], pin};
         if (sh_q[1] == sh_q[2]) begin
            level <= sh_q[2];
         end
      end
   end
endmodule // pin_sync
`default_nettype wire

/* logic/lane_select.sv */
// byte-lane encoding and data steering for one access
`default_nettype none
`include "cpu_bus_map.svh"
module lane_select (
   input  wire logic [15:0] addr,
   input  wire logic        word,
   input  wire logic [15:0] wdata,
   output logic [1:0]       lanes,
   output logic [15:0]      bus_wdata
);
   always_comb begin
      if (word && !addr[0]) begin
         lanes = `LANE_WORD;
      end else if (addr[0]) begin
         lanes = `LANE_HIGH;
      end else begin
         lanes = `LANE_LOW;
      end
      // odd bytes ride the high lines
      if (!word && addr[0]) begin
         bus_wdata = {wdata[7:0], 8'h00};
      end else begin
         bus_wdata = wdata;
      end
   end
endmodule // lane_select
`default_nettype wire

/* logic/cpu_local_bus_cycle.sv */
// bus cycle engine for a multiplexed 16-bit local bus
`default_nettype none
`include "cpu_bus_map.svh"
module cpu_local_bus_cycle (
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire logic                     req_valid,
   input  wire cpu_bus_pkg::cycle_kind_t req_kind,
   input  wire logic [19:0]              req_addr,
   input  wire logic                     req_word,
   input  wire logic [15:0]              req_wdata,
   output logic                          req_ready,
   output logic                          done,
   output logic [15:0]                   rdata,
   output logic [9:0]                    vector_ptr,
   output logic                          vector_valid,
   input  wire logic                     bus_mode_strap,
   input  wire logic                     ready_pin,
   input  wire logic [15:0]              muxed_addr_data_bus_i,
   output logic [15:0]                   muxed_addr_data_bus_o,
   output logic [15:0]                   muxed_addr_data_bus_oe,
   output logic [3:0]                    addr_high_o,
   output logic                          addr_latch_enable,
   output logic                          mem_io_select,
   output logic                          read_strobe_n,
   output logic                          write_strobe_n,
   output logic                          int_ack_strobe_n,
   output logic                          byte_high_enable_n,
   output logic                          xcvr_direction,
   output logic                          xcvr_data_enable_n,
   output logic [2:0]                    cycle_status,
   output logic                          bus_lock_n
);
   cpu_bus_pkg::bus_state_t   state_q;
   cpu_bus_pkg::cycle_kind_t  kind_q;
   logic        ready_s;
   logic        min_mode_q;
   logic        strap_s;
   logic [15:0] addr_q;
   logic        word_q;
   logic [15:0] wdata_q;
   logic        second_ack_q;
   logic [1:0]  lanes;
   logic [15:0] bus_wdata;
   logic        is_read;
   logic        is_write;
   logic        is_ack;
   logic        is_io;

   function automatic logic [2:0] status_code(
      input cpu_bus_pkg::cycle_kind_t k);
      case (k)
         cpu_bus_pkg::cyc_int_ack:   status_code = `ST_INT_ACK;
         cpu_bus_pkg::cyc_io_read:   status_code = `ST_IO_READ;
         cpu_bus_pkg::cyc_io_write:  status_code = `ST_IO_WRITE;
         cpu_bus_pkg::cyc_halt:      status_code = `ST_HALT;
         cpu_bus_pkg::cyc_code_read: status_code = `ST_CODE_READ;
         cpu_bus_pkg::cyc_mem_read:  status_code = `ST_MEM_READ;
         default:                    status_code = `ST_MEM_WRITE;
      endcase
   endfunction

   pin_sync #(.init(1'b0)) u_ready (
      .clk    (clk),
      .resetn (resetn),
      .pin    (ready_pin),
      .level  (ready_s)
   );
   pin_sync #(.init(1'b1)) u_strap (
      .clk    (clk),
      .resetn (resetn),
      .pin    (bus_mode_strap),
      .level  (strap_s)
   );
   lane_select u_lanes (
      .addr      (addr_q),
      .word      (word_q),
      .wdata     (wdata_q),
      .lanes     (lanes),
      .bus_wdata (bus_wdata)
   );

   assign is_read  = kind_q == cpu_bus_pkg::cyc_code_read ||
                     kind_q == cpu_bus_pkg::cyc_mem_read ||
                     kind_q == cpu_bus_pkg::cyc_io_read;
   assign is_write = kind_q == cpu_bus_pkg::cyc_mem_write ||
                     kind_q == cpu_bus_pkg::cyc_io_write;
   assign is_ack   = kind_q == cpu_bus_pkg::cyc_int_ack;
   assign is_io    = kind_q == cpu_bus_pkg::cyc_io_read ||
                     kind_q == cpu_bus_pkg::cyc_io_write;

   // strap is static; track its synchronised level while idle only
   always_ff @(posedge clk) begin
      if (!resetn) begin
         min_mode_q <= 1'b1;
      end else if (state_q == cpu_bus_pkg::idle) begin
         min_mode_q <= strap_s;
      end
   end

   // fixed state order, waits before four
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= cpu_bus_pkg::idle;
      end else begin
         case (state_q)
            cpu_bus_pkg::idle:
               // second ack waits for ready to fall: a stale ready
               // from the first ack would end it before the type byte
               if (second_ack_q ? !ready_s : req_valid) begin
                  state_q <= cpu_bus_pkg::state_one;
               end
            cpu_bus_pkg::state_one: begin
               if (kind_q == cpu_bus_pkg::cyc_halt) begin
                  state_q <= cpu_bus_pkg::idle;
               end else begin
                  state_q <= cpu_bus_pkg::state_two;
               end
            end
            cpu_bus_pkg::state_two:
               state_q <= cpu_bus_pkg::state_three;
            cpu_bus_pkg::state_three, cpu_bus_pkg::wait_state: begin
               if (ready_s) begin
                  state_q <= cpu_bus_pkg::state_four;
               end else begin
                  state_q <= cpu_bus_pkg::wait_state;
               end
            end
            default:
               state_q <= cpu_bus_pkg::idle;
         endcase
      end
   end

   // request capture; second acknowledge is self-issued
   always_ff @(posedge clk) begin
      if (!resetn) begin
         kind_q       <= cpu_bus_pkg::cyc_halt;
         addr_q       <= 16'h0000;
         word_q       <= 1'b0;
         wdata_q      <= 16'h0000;
         addr_high_o  <= 4'h0;
         second_ack_q <= 1'b0;
      end else begin
         if (state_q == cpu_bus_pkg::idle && req_valid && !second_ack_q)
         begin
            kind_q      <= req_kind;
            addr_q      <= req_addr[15:0];
            addr_high_o <= req_addr[19:16];
            word_q      <= req_word;
            wdata_q     <= req_wdata;
         end
         if (state_q == cpu_bus_pkg::state_four && is_ack) begin
            second_ack_q <= !second_ack_q;
         end
      end
   end

   // bus pins and strobes, all registered on the next state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         addr_latch_enable      <= 1'b0;
         muxed_addr_data_bus_o  <= 16'h0000;
         muxed_addr_data_bus_oe <= 16'h0000;
         read_strobe_n          <= 1'b1;
         write_strobe_n         <= 1'b1;
         int_ack_strobe_n       <= 1'b1;
         byte_high_enable_n     <= 1'b1;
         mem_io_select          <= 1'b1;
         xcvr_direction         <= 1'b1;
         xcvr_data_enable_n     <= 1'b1;
         cycle_status           <= `ST_PASSIVE;
      end else begin
         addr_latch_enable <= state_q == cpu_bus_pkg::state_one;
         case (state_q)
            cpu_bus_pkg::state_one: begin
               muxed_addr_data_bus_o  <= {addr_q[15:1], lanes[0]};
               muxed_addr_data_bus_oe <= is_ack ? 16'h0000 : 16'hffff;
               byte_high_enable_n <= lanes[1];
               mem_io_select <= !is_io;
               xcvr_direction <= is_write;
               cycle_status <= min_mode_q ? `ST_PASSIVE :
                               status_code(kind_q);
            end
            cpu_bus_pkg::state_two: begin
               if (is_write) begin
                  muxed_addr_data_bus_o  <= bus_wdata;
                  muxed_addr_data_bus_oe <= 16'hffff;
                  // write strobe at start of two
                  write_strobe_n <= !min_mode_q;
               end else begin
                  muxed_addr_data_bus_oe <= 16'h0000;
               end
               xcvr_data_enable_n <= !min_mode_q;
            end
            cpu_bus_pkg::state_three: begin
               // read strobe lags one state for bus float
               read_strobe_n    <= !(min_mode_q && is_read);
               int_ack_strobe_n <= !(min_mode_q && is_ack);
            end
            cpu_bus_pkg::wait_state: begin
               if (ready_s) begin
                  cycle_status <= `ST_PASSIVE;
               end
            end
            cpu_bus_pkg::state_four: begin
               read_strobe_n          <= 1'b1;
               write_strobe_n         <= 1'b1;
               int_ack_strobe_n       <= 1'b1;
               xcvr_data_enable_n     <= 1'b1;
               muxed_addr_data_bus_oe <= 16'h0000;
               cycle_status           <= `ST_PASSIVE;
            end
            default: begin
               muxed_addr_data_bus_oe <= 16'h0000;
               // halt status lasts one clock; idle is passive
               cycle_status           <= `ST_PASSIVE;
            end
         endcase
      end
   end

   // lock from one of first to one of second
   always_ff @(posedge clk) begin
      if (!resetn) begin
         bus_lock_n <= 1'b1;
      end else if (state_q == cpu_bus_pkg::state_one && is_ack) begin
         bus_lock_n <= second_ack_q;
      end
   end

   // read capture and vector pointer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata        <= 16'h0000;
         vector_ptr   <= 10'h000;
         vector_valid <= 1'b0;
         done         <= 1'b0;
         req_ready    <= 1'b0;
      end else begin
         done         <= 1'b0;
         vector_valid <= 1'b0;
         req_ready    <= state_q == cpu_bus_pkg::idle && !second_ack_q
                         && !req_valid;
         if (state_q == cpu_bus_pkg::state_one &&
             kind_q == cpu_bus_pkg::cyc_halt) begin
            done <= 1'b1;
         end
         if (state_q == cpu_bus_pkg::state_four) begin
            done <= !(is_ack && !second_ack_q);
            if (is_read) begin
               rdata <= muxed_addr_data_bus_i;
            end
            if (is_ack && second_ack_q) begin
               vector_ptr <= {muxed_addr_data_bus_i[7:0], 2'h0};
               vector_valid <= 1'b1;
               rdata <= {8'h00, muxed_addr_data_bus_i[7:0]};
            end
         end
      end
   end
endmodule // cpu_local_bus_cycle
`default_nettype wire

/* bench/cpu_local_bus_cycle_checker.sv */
// concurrent checks on the local bus cycle engine ports
`default_nettype none
`include "cpu_bus_map.svh"
module bus_cycle_checker (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        addr_latch_enable,
   input wire logic        mem_io_select,
   input wire logic        read_strobe_n,
   input wire logic        write_strobe_n,
   input wire logic        int_ack_strobe_n,
   input wire logic [15:0] muxed_addr_data_bus_oe,
   input wire logic        done,
   input wire logic [15:0] rdata,
   input wire logic [9:0]  vector_ptr,
   input wire logic        vector_valid,
   input wire logic        bus_mode_strap,
   input wire logic [2:0]  cycle_status,
   input wire logic        bus_lock_n,
   input wire logic        xcvr_direction,
   input wire logic        xcvr_data_enable_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_float;
      muxed_addr_data_bus_oe == 16'h0;
   endsequence
   sequence s_rd_on;
      $fell(read_strobe_n);
   endsequence
   AST_ALE_PULSE: assert property ($rose(addr_latch_enable)
      |=> !addr_latch_enable) else $error("latch strobe too long");
   AST_MIO_HELD: assert property (!read_strobe_n || !write_strobe_n
      |-> $stable(mem_io_select)) else $error("select moved in cycle");
   AST_READ_FLOAT: assert property (s_rd_on |-> s_float
      ##0 $past(muxed_addr_data_bus_oe) == 16'h0) else $error("read early");
   AST_WRITE_EARLY: assert property ($fell(write_strobe_n)
      |-> $past(addr_latch_enable) && muxed_addr_data_bus_oe != 16'h0)
      else $error("write strobe or data late");
   AST_ACK_FLOAT: assert property (!int_ack_strobe_n |-> s_float)
      else $error("bus driven in acknowledge");
   AST_VECTOR: assert property (vector_valid
      |-> vector_ptr == {rdata[7:0], 2'h0}) else $error("bad vector");
   AST_LOCK_PAIR: assert property ($fell(bus_lock_n)
      |-> ##[1:40] ($fell(int_ack_strobe_n)
      || cycle_status == `ST_INT_ACK)) else $error("lock alone");
   AST_MAX_QUIET: assert property (!bus_mode_strap
      && !$past(bus_mode_strap, 8)
      |-> read_strobe_n && write_strobe_n && int_ack_strobe_n)
      else $error("strobe in max mode");
   AST_MIN_PASSIVE: assert property (bus_mode_strap
      && $past(bus_mode_strap, 8) |-> cycle_status == 3'h7)
      else $error("status in min mode");
   AST_XCVR: assert property (!read_strobe_n
      |-> !xcvr_data_enable_n && !xcvr_direction) else $error("xcvr");
   AST_READ_END: assert property ($rose(read_strobe_n) |-> done)
      else $error("read ended without done");
   AST_DONE_PULSE: assert property (done |=> !done)
      else $error("done too long");
endmodule // bus_cycle_checker
bind cpu_local_bus_cycle bus_cycle_checker u_bus_cycle_checker (
   .clk(clk), .resetn(resetn), .addr_latch_enable(addr_latch_enable),
   .mem_io_select(mem_io_select), .read_strobe_n(read_strobe_n),
   .write_strobe_n(write_strobe_n), .int_ack_strobe_n(int_ack_strobe_n),
   .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe), .done(done),
   .rdata(rdata), .vector_ptr(vector_ptr), .vector_valid(vector_valid),
   .bus_mode_strap(bus_mode_strap), .cycle_status(cycle_status),
   .bus_lock_n(bus_lock_n), .xcvr_direction(xcvr_direction),
   .xcvr_data_enable_n(xcvr_data_enable_n));
`default_nettype wire

/* bench/bus_device_model.sv */
// far-side memory, io port and interrupt controller
`default_nettype none
`include "cpu_bus_map.svh"
module bus_device_model #(
   parameter logic [7:0] int_type = 8'h2c
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        addr_latch_enable,
   input  wire logic        read_strobe_n,
   input  wire logic        write_strobe_n,
   input  wire logic        int_ack_strobe_n,
   input  wire logic        xcvr_direction,
   input  wire logic        xcvr_data_enable_n,
   input  wire logic [2:0]  cycle_status,
   input  wire logic [15:0] bus_o,
   input  wire logic [15:0] bus_oe,
   input  wire logic [3:0]  waits,
   output logic [15:0]      bus_dev,
   output logic             ready_pin,
   output logic [15:0]      addr_q,
   output logic [15:0]      wdata_q,
   output logic [1:0]       acks_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  cnt_q;
   logic [15:0] last_q;
   logic        ia_q;
   logic        act;
   logic        drive;
   logic        xcvr_on;
   // in max mode the decoded status alone opens a cycle
   assign act = !read_strobe_n || !int_ack_strobe_n || !write_strobe_n
                || cycle_status != 3'h7;
   // transceiver follows direction and enable, gated off
   // while the local interrupt controller answers by itself
   assign xcvr_on = int_ack_strobe_n && (cycle_status != 3'h7
                    || (!xcvr_data_enable_n && !xcvr_direction));
   assign drive = act && bus_oe == 16'h0 && !addr_latch_enable
                  && (xcvr_on || !int_ack_strobe_n);
   assign bus_dev = !drive ? ~last_q : !int_ack_strobe_n
      ? {~last_q[15:8], acks_q == 2'h2 ? int_type : 8'h00}
      : {~addr_q[7:0], addr_q[7:0]};
   assign ready_pin = act && cnt_q >= waits;
   always_ff @(posedge clk) begin
      cnt_q <= !act ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
      last_q <= !resetn ? 16'h0 : (drive ? bus_dev : bus_o);
      ia_q <= int_ack_strobe_n;
      if (addr_latch_enable) addr_q <= bus_o;
      // normal strobe, or status-timed write command in max mode
      if (!write_strobe_n || cycle_status == `ST_MEM_WRITE
          || cycle_status == `ST_IO_WRITE) wdata_q <= bus_o;
      if (!resetn) acks_q <= 2'h0;
      else if (ia_q && !int_ack_strobe_n) acks_q <= acks_q + 2'h1;
   end
endmodule // bus_device_model
`default_nettype wire

/* bench/cpu_local_bus_cycle_test.sv */
// directed scenarios for the local bus cycle engine
`default_nettype none
`include "cpu_bus_map.svh"
module cpu_local_bus_cycle_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] int_type = 8'h2c;
   logic        clk = 1'b0, resetn = 1'b0, req_valid = 1'b0;
   logic        req_word = 1'b0, strap = 1'b1;
   logic [19:0] req_addr = 20'h0;
   logic [15:0] req_wdata = 16'h0;
   logic [3:0]  waits = 4'h0;
   cpu_bus_pkg::cycle_kind_t req_kind = cpu_bus_pkg::cyc_mem_read;
   logic        done, vec_valid, ale, mio, rd_n, wr_n, ia_n, bhe_n, ready;
   logic        dir, den_n, lock_n, lat_bhe, lat_mio, rdy;
   logic [3:0]  a_hi;
   logic [15:0] rdata, bus_o, bus_oe, bus_i, bus_dev, m_wdata, lat_bus;
   logic [9:0]  vec_ptr, vec_seen;
   logic [2:0]  status, last_st;
   logic [1:0]  acks;
   int          n_fail = 0, cmp_count = 0, ale_cnt = 0;
   assign bus_i = (bus_o & bus_oe) | (bus_dev & ~bus_oe);
   initial forever #4 clk = ~clk;
   cpu_local_bus_cycle u_cpu_local_bus_cycle (.clk(clk), .resetn(resetn),
      .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
      .req_word(req_word), .req_wdata(req_wdata), .req_ready(rdy),
      .done(done),
      .rdata(rdata), .vector_ptr(vec_ptr), .vector_valid(vec_valid),
      .bus_mode_strap(strap), .ready_pin(ready),
      .muxed_addr_data_bus_i(bus_i), .muxed_addr_data_bus_o(bus_o),
      .muxed_addr_data_bus_oe(bus_oe), .addr_high_o(a_hi),
      .addr_latch_enable(ale), .mem_io_select(mio), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .int_ack_strobe_n(ia_n),
      .byte_high_enable_n(bhe_n), .xcvr_direction(dir),
      .xcvr_data_enable_n(den_n), .cycle_status(status), .bus_lock_n(lock_n));
   bus_device_model #(.int_type(int_type)) u_bus_device_model (.clk(clk),
      .resetn(resetn), .addr_latch_enable(ale), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .int_ack_strobe_n(ia_n), .cycle_status(status),
      .bus_o(bus_o), .bus_oe(bus_oe), .waits(waits), .bus_dev(bus_dev),
      .ready_pin(ready), .addr_q(), .wdata_q(m_wdata), .acks_q(acks),
      .xcvr_direction(dir), .xcvr_data_enable_n(den_n));
   always @(negedge clk) begin
      if (ale === 1'b1) {lat_bus, lat_bhe, lat_mio} <= {bus_o, bhe_n, mio};
      if (ale === 1'b1) ale_cnt <= ale_cnt + 1;
      if (status !== 3'h7) last_st <= status;
      if (vec_valid === 1'b1) vec_seen <= vec_ptr;
   end
   task automatic chk(input logic [15:0] seen, exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results;
      if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one request, driven on the first edge and taken on the second; n is cycles from take to done
   task automatic cyc(input cpu_bus_pkg::cycle_kind_t k,
         input logic [19:0] a, input logic w, input logic [15:0] d,
         output int n);
      @(posedge clk);
      req_kind <= k;
      {req_valid, req_addr, req_word, req_wdata} <= {1'b1, a, w, d};
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      #1;
      while (done !== 1'b1 && n < 80) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 80) n_fail++;
   endtask
   task automatic t_lanes;
      cpu_bus_pkg::cycle_kind_t ks[5] = '{cpu_bus_pkg::cyc_mem_read,
         cpu_bus_pkg::cyc_mem_read, cpu_bus_pkg::cyc_io_read,
         cpu_bus_pkg::cyc_io_write, cpu_bus_pkg::cyc_mem_write};
      logic [19:0] as[5] = '{20'h00124, 20'h00125, 20'h00036, 20'h00041,
         20'h50ba2};
      logic [4:0]  ws = 5'b10011;
      logic [2:0]  ex[5] = '{3'b001, 3'b011, 3'b100, 3'b010, 3'b001};
      int n;
      for (int i = 0; i < 5; i++) begin
         cyc(ks[i], as[i], ws[i], i == 3 ? 16'h00a7 : 16'h5e3c, n);
         chk({lat_bhe, lat_bus[0], lat_mio}, ex[i], "lanes");
         chk(lat_bus, as[i][15:0], "address");
         chk(16'(a_hi), 16'(as[i][19:16]), "high address");
         if (i == 0) chk(rdata, 16'hdb24, "read word");
         if (i == 3) chk(m_wdata[15:8], 8'ha7, "odd byte");
         if (i == 4) chk(m_wdata, 16'h5e3c, "write word");
      end
   endtask
   task automatic t_waits;
      int n0, n3;
      cyc(cpu_bus_pkg::cyc_mem_read, 20'h00200, 1'b1, 16'h0, n0);
      @(posedge clk) waits <= 4'h3;
      cyc(cpu_bus_pkg::cyc_mem_read, 20'h00202, 1'b1, 16'h0, n3);
      @(posedge clk) waits <= 4'h0;
      chk(16'(n3 - n0), 16'h3, "wait states");
      chk(rdata, 16'hfd02, "slow read");
   endtask
   task automatic t_halt;
      int n, a0;
      a0 = ale_cnt;
      cyc(cpu_bus_pkg::cyc_halt, 20'h0, 1'b0, 16'h0, n);
      repeat (2) @(posedge clk);
      chk(16'(n), 16'h1, "halt length");
      chk(16'(rdy), 16'h1, "request ready");
      chk(16'(ale_cnt - a0), 16'h1, "halt latch");
   endtask
   task automatic t_ack;
      int n;
      cyc(cpu_bus_pkg::cyc_int_ack, 20'h0, 1'b0, 16'h0, n);
      chk(rdata[7:0], int_type, "type byte");
      repeat (2) @(posedge clk);
      chk(16'(acks), 16'h2, "ack count");
      chk(vec_seen, {int_type, 2'h0}, "vector");
   endtask
   task automatic t_max;
      cpu_bus_pkg::cycle_kind_t ks[7] = '{cpu_bus_pkg::cyc_code_read,
         cpu_bus_pkg::cyc_mem_read, cpu_bus_pkg::cyc_io_read,
         cpu_bus_pkg::cyc_mem_write, cpu_bus_pkg::cyc_io_write,
         cpu_bus_pkg::cyc_int_ack, cpu_bus_pkg::cyc_halt};
      logic [2:0] cs[7] = '{`ST_CODE_READ, `ST_MEM_READ, `ST_IO_READ,
         `ST_MEM_WRITE, `ST_IO_WRITE, `ST_INT_ACK, `ST_HALT};
      int n;
      @(posedge clk) strap <= 1'b0;
      repeat (10) @(posedge clk);
      for (int i = 0; i < 7; i++) begin
         cyc(ks[i], 20'h00300, 1'b1, 16'h1234, n);
         repeat (2) @(posedge clk);
         chk(16'(last_st), 16'(cs[i]), "status");
         if (i == 3) chk(m_wdata, 16'h1234, "max write");
      end
      @(posedge clk) strap <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (6) @(posedge clk);
      t_lanes;
      t_waits;
      t_halt;
      t_ack;
      t_max;
      results;
   end
   // run needs a few hundred cycles
   initial begin
      #100000;
      n_fail++;
      results;
   end
endmodule // cpu_local_bus_cycle_test
`default_nettype wire
